//--- src/pbus_pkg.sv
// Behaviour
// R1: On low hold request, finish current transfer, then float address, data, strobe, read/write.
// R2: During hold start no transfers; resume when hold request high or ignore bit set.
// R3: Drive grant low in answer to low hold request once bus floats.
// R4: Grant returns high when request high; stays high while ignore bit set.
// R5: A transfer completes only on a cycle where ready is asserted.
// R6: During reset stay idle; after release start fetching at the reset vector.
// R7: Shutdown active floats every output and two-way pin and stops operation.
// R8: After shutdown, system must reset with shutdown high to restore state.
// R9: Acknowledge pulse issued only when the acknowledge instruction executes.
// R10: Flag pins act as general-purpose inputs or outputs, or interlock handshake. Code gives general-purpose use only, no handshake.
// R11: Read/write output high for reads, low for writes.
// R12: Hold request sampled on the clock; bus released only at transfer boundary.
`default_nettype none
package pbus_pkg;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 32;
  localparam logic [23:0] RESET_VECTOR_ADDR = 24'h00_0000;
  localparam logic [1:0]  FLAG_OUT_RST = 2'h0;
  localparam logic [1:0]  FLAG_DIR_RST = 2'h0;
  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_XFER, ST_HOLD} bus_state_t;
endpackage
`default_nettype wire

//--- src/hold_if.sv
`default_nettype none
// Hold handshake between the bus controller and its arbiter
interface hold_if;
  logic req;      // Hold wanted (sampled, active high)
  logic at_bound; // No transfer in flight
  logic granted;  // Bus handed away
  modport arb (input req, input at_bound, output granted);
  modport ctl (output req, output at_bound, input granted);
endinterface
`default_nettype wire

//--- src/hold_arbiter.sv
`default_nettype none
module hold_arbiter (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic ignore_hold_bit,
  hold_if.arb       h
);
  typedef struct packed {
    logic granted;
  } arb_state_t;
  arb_state_t s_q;
  arb_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (ignore_hold_bit || !h.req)
      s_d.granted = 1'b0; // R4
    else if (h.at_bound)
      s_d.granted = 1'b1; // R12
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign h.granted = s_q.granted;

  property p_grant_boundary;
    @(posedge ref_clk) disable iff (sys_rst)
      $rose(s_q.granted) |-> $past(h.at_bound);
  endproperty
  a_grant_boundary: assert property (p_grant_boundary) else $error("grant mid-transfer"); // R12

  property p_ignore;
    @(posedge ref_clk) disable iff (sys_rst)
      $past(ignore_hold_bit) |-> !s_q.granted;
  endproperty
  a_ignore: assert property (p_ignore) else $error("grant while ignoring hold"); // R4
endmodule // hold_arbiter
`default_nettype wire

//--- src/pbus_ctrl.sv
`default_nettype none
module pbus_ctrl #(
  parameter int unsigned AW = pbus_pkg::ADDR_W,
  parameter int unsigned DW = pbus_pkg::DATA_W
) (
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          reset_n,
  input  wire logic          shutdown_float_n,
  input  wire logic          hold_req_n,
  input  wire logic          ready_n,
  input  wire logic          ignore_hold_bit,
  input  wire logic          req_valid,
  input  wire logic          req_write,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  input  wire logic          int_ack_pulse_n_exec,
  input  wire logic [1:0]    flag_out_set,
  input  wire logic [1:0]    flag_dir_set,
  input  wire logic          flag_load,
  input  wire logic [DW-1:0] data_i,
  input  wire logic [1:0]    ext_flag_pins_i,
  output logic               req_ready,
  output logic               rsp_valid,
  output logic [DW-1:0]      rsp_rdata,
  output logic [1:0]         flag_in,
  output logic [AW-1:0]      addr_o,
  output logic               addr_oe,
  output logic [DW-1:0]      data_o,
  output logic               data_oe,
  output logic               access_strobe_n,
  output logic               ctl_oe,
  output logic               read_write,
  output logic               bus_hold_grant_n,
  output logic               hold_grant_oe,
  output logic               int_ack_pulse_n,
  output logic               int_ack_pulse_n_oe,
  output logic [1:0]         ext_flag_pins_o,
  output logic [1:0]         ext_flag_pins_oe
);
  if (AW != 24 || DW != 32)
  begin : g_width_check
    $error("pbus_ctrl supports only a 24-bit address and 32-bit data bus");
  end

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    pbus_pkg::bus_state_t st;
    logic                 hold_s;
    logic [AW-1:0]        addr;
    logic [DW-1:0]        wdata;
    logic                 wr;
    logic                 strobe_n;
    logic                 drive;
    logic                 grant_n;
    logic                 int_ack_pulse_n_n;
    logic                 req_rdy;
    logic                 rsp_v;
    logic [DW-1:0]        rdata;
    logic [1:0]           fl_out;
    logic [1:0]           fl_dir;
    logic [1:0]           fl_in;
    logic                 rw;
    logic                 aoe;
    logic                 coe;
    logic                 doe;
    logic                 goe;
    logic                 ioe;
    logic [1:0]           foe;
  } ctl_state_t;
  ctl_state_t s_q;
  ctl_state_t s_d;
  hold_if     h ();
  logic       sd;
  logic       flt;

  assign sd = !shutdown_float_n;
  assign flt = sd || !reset_n;
  assign h.req = s_q.hold_s;
  assign h.at_bound = (s_q.st == pbus_pkg::ST_IDLE) || (s_q.st == pbus_pkg::ST_HOLD);

  hold_arbiter u_arb (
    .ref_clk         (ref_clk),
    .sys_rst         (sys_rst),
    .ignore_hold_bit (ignore_hold_bit),
    .h               (h)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    s_d = s_q;
    s_d.hold_s = !hold_req_n; // R12
    s_d.rsp_v = 1'b0;
    s_d.int_ack_pulse_n_n = 1'b1;
    s_d.req_rdy = 1'b0;
    s_d.fl_in = ext_flag_pins_i; // R10
    if (flag_load)
    begin
      s_d.fl_out = flag_out_set; // R10
      s_d.fl_dir = flag_dir_set;
    end
    if (int_ack_pulse_n_exec)
      s_d.int_ack_pulse_n_n = 1'b0; // R9
    if (!reset_n)
    begin
      s_d.st = pbus_pkg::ST_BOOT; // R6
      s_d.strobe_n = 1'b1;
      s_d.drive = 1'b0;
      s_d.int_ack_pulse_n_n = 1'b1;
      s_d.grant_n = 1'b1;
      s_d.fl_out = pbus_pkg::FLAG_OUT_RST; // R6
      s_d.fl_dir = pbus_pkg::FLAG_DIR_RST;
    end
    else if (sd)
    begin
      // Frozen while floated; contents are not trusted until the next reset
      s_d = s_q; // R7
      s_d.hold_s = !hold_req_n;
      s_d.rsp_v = 1'b0;
      s_d.req_rdy = 1'b0;
      s_d.int_ack_pulse_n_n = 1'b1;
    end
    else
    begin
      unique case (s_q.st)
        pbus_pkg::ST_BOOT:
        begin
          // First fetch from the reset vector
          s_d.addr = pbus_pkg::RESET_VECTOR_ADDR; // R6
          s_d.wr = 1'b0;
          s_d.strobe_n = 1'b0;
          s_d.drive = 1'b1;
          s_d.st = pbus_pkg::ST_XFER;
        end
        pbus_pkg::ST_IDLE:
        begin
          s_d.drive = 1'b1;
          if (h.granted)
          begin
            s_d.drive = 1'b0; // R1
            s_d.strobe_n = 1'b1;
            s_d.st = pbus_pkg::ST_HOLD;
          end
          else if (req_valid && (!s_q.hold_s || ignore_hold_bit)) // R2
          begin
            s_d.addr = req_addr;
            s_d.wdata = req_wdata;
            s_d.wr = req_write;
            s_d.strobe_n = 1'b0;
            s_d.req_rdy = 1'b1;
            s_d.st = pbus_pkg::ST_XFER;
          end
        end
        pbus_pkg::ST_XFER:
        begin
          if (!ready_n)
          begin
            s_d.strobe_n = 1'b1; // R5
            s_d.rsp_v = !s_q.wr;
            s_d.rdata = data_i;
            s_d.st = pbus_pkg::ST_IDLE;
          end
        end
        pbus_pkg::ST_HOLD:
        begin
          s_d.grant_n = !h.granted; // R3
          s_d.drive = 1'b0;
          if (!h.granted)
          begin
            s_d.grant_n = 1'b1; // R4
            s_d.st = pbus_pkg::ST_IDLE; // R2
          end
        end
      endcase
    end
    // Enables are worked out one cycle ahead so every pin comes straight from a flop
    s_d.rw = !s_d.wr; // R11
    s_d.aoe = s_d.drive && !flt; // R1
    s_d.coe = s_d.drive && !flt;
    s_d.doe = s_d.drive && s_d.wr && !s_d.strobe_n && !flt;
    s_d.goe = !flt; // R7
    s_d.ioe = !flt;
    s_d.foe = flt ? 2'h0 : s_d.fl_dir; // R10
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.st <= pbus_pkg::ST_BOOT;
      s_q.strobe_n <= 1'b1;
      s_q.grant_n <= 1'b1;
      s_q.int_ack_pulse_n_n <= 1'b1;
      s_q.fl_out <= pbus_pkg::FLAG_OUT_RST;
      s_q.fl_dir <= pbus_pkg::FLAG_DIR_RST;
      s_q.rw <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // Pins
  // ==========================================================
  assign addr_o = s_q.addr;
  assign addr_oe = s_q.aoe; // R1
  assign data_o = s_q.wdata;
  assign data_oe = s_q.doe;
  assign access_strobe_n = s_q.strobe_n;
  assign ctl_oe = s_q.coe;
  assign read_write = s_q.rw; // R11
  assign bus_hold_grant_n = s_q.grant_n;
  assign hold_grant_oe = s_q.goe; // R7
  assign int_ack_pulse_n = s_q.int_ack_pulse_n_n;
  assign int_ack_pulse_n_oe = s_q.ioe;
  assign ext_flag_pins_o = s_q.fl_out;
  assign ext_flag_pins_oe = s_q.foe; // R10
  assign req_ready = s_q.req_rdy;
  assign rsp_valid = s_q.rsp_v;
  assign rsp_rdata = s_q.rdata;
  assign flag_in = s_q.fl_in;

  // ==========================================================
  // Checks
  // ==========================================================
  property p_float_on_grant;
    @(posedge ref_clk) disable iff (sys_rst)
      !bus_hold_grant_n |-> !addr_oe && !data_oe && !ctl_oe;
  endproperty
  a_float_on_grant: assert property (p_float_on_grant) else $error("bus driven in hold"); // R1

  property p_no_start_in_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      s_q.st == pbus_pkg::ST_HOLD |=> s_q.st != pbus_pkg::ST_XFER;
  endproperty
  a_no_start_in_hold: assert property (p_no_start_in_hold) else $error("transfer in hold"); // R2

  property p_grant_needs_req;
    @(posedge ref_clk) disable iff (sys_rst)
      !bus_hold_grant_n |-> $past(s_q.hold_s, 1) || $past(s_q.hold_s, 2);
  endproperty
  a_grant_needs_req: assert property (p_grant_needs_req) else $error("grant without request"); // R3

  property p_xfer_ends_on_ready;
    @(posedge ref_clk) disable iff (sys_rst)
      (s_q.st == pbus_pkg::ST_XFER && ready_n && reset_n && shutdown_float_n)
        |=> s_q.st == pbus_pkg::ST_XFER && !access_strobe_n;
  endproperty
  a_xfer_ends_on_ready: assert property (p_xfer_ends_on_ready) else $error("ended without ready"); // R5

  property p_boot_vector;
    @(posedge ref_clk) disable iff (sys_rst)
      (s_q.st == pbus_pkg::ST_BOOT && reset_n && shutdown_float_n)
        |=> s_q.addr == pbus_pkg::RESET_VECTOR_ADDR && !access_strobe_n;
  endproperty
  a_boot_vector: assert property (p_boot_vector) else $error("no reset vector fetch"); // R6

  property p_shutdown_float;
    @(posedge ref_clk) disable iff (sys_rst)
      !shutdown_float_n |=> !addr_oe && !int_ack_pulse_n_oe && ext_flag_pins_oe == 2'h0;
  endproperty
  a_shutdown_float: assert property (p_shutdown_float) else $error("pin driven in shutdown"); // R7

  property p_int_ack_pulse_n_cause;
    @(posedge ref_clk) disable iff (sys_rst)
      !int_ack_pulse_n |-> $past(int_ack_pulse_n_exec) ##1 (int_ack_pulse_n || $past(int_ack_pulse_n_exec));
  endproperty
  a_int_ack_pulse_n_cause: assert property (p_int_ack_pulse_n_cause) else $error("stray acknowledge"); // R9

  property p_rw_level;
    @(posedge ref_clk) disable iff (sys_rst)
      (!access_strobe_n && ctl_oe) |-> read_write == !data_oe;
  endproperty
  a_rw_level: assert property (p_rw_level) else $error("read/write level wrong"); // R11

  property p_ignore_resume;
    @(posedge ref_clk) disable iff (sys_rst)
      (s_q.st == pbus_pkg::ST_IDLE && !h.granted && req_valid && ignore_hold_bit
        && reset_n && shutdown_float_n) |=> s_q.st == pbus_pkg::ST_XFER;
  endproperty
  a_ignore_resume: assert property (p_ignore_resume) else $error("ignore bit blocked start"); // R2
endmodule // pbus_ctrl
`default_nettype wire

//--- sim/bus_mem_model.sv
`default_nettype none
// ==========================================
// External memory answering on the primary bus
module bus_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        access_strobe_n,
  input  wire logic        ctl_oe,
  input  wire logic [23:0] addr_o,
  input  wire logic [3:0]  wait_cycles,
  output logic             ready_n,
  output logic [31:0]      rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_q;
  initial
  begin
    ready_n = 1'b1;
    rd_data = 32'h0000_0000;
    cnt_q   = 4'h0;
  end
  // Ready shows for one cycle only; stale data is inverted so it never looks valid
  always @(posedge ref_clk)
  begin
    if (!ready_n)
    begin
      ready_n <= 1'b1;
      rd_data <= ~rd_data;
      cnt_q   <= 4'h0;
    end
    else if (ctl_oe && !access_strobe_n)
    begin
      if (cnt_q == wait_cycles)
      begin
        ready_n <= 1'b0;
        rd_data <= {8'h5a, addr_o};
      end
      else
        cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // bus_mem_model
`default_nettype wire

//--- sim/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, sys_rst, reset_n, shutdown_float_n, hold_req_n, ready_n;
  logic        ignore_hold_bit, req_valid, req_write, int_ack_pulse_n_exec, flag_load;
  logic        req_ready, rsp_valid, addr_oe, data_oe, access_strobe_n, ctl_oe;
  logic        read_write, bus_hold_grant_n, hold_grant_oe, int_ack_pulse_n, int_ack_pulse_n_oe;
  logic [1:0]  flag_out_set, flag_dir_set, flag_in, flag_ext;
  logic [1:0]  ext_flag_pins_i, ext_flag_pins_o, ext_flag_pins_oe;
  logic [3:0]  wait_cycles;
  logic [23:0] req_addr, addr_o;
  logic [31:0] req_wdata, data_i, rsp_rdata, data_o, rd_data;
  int          mismatches = 0;
  int          n_checks = 0;
  // ==========================================
  // Pins resolved from every driver
  assign data_i = data_oe ? data_o : rd_data;
  assign ext_flag_pins_i = (ext_flag_pins_oe & ext_flag_pins_o) | (~ext_flag_pins_oe & flag_ext);
  pbus_ctrl pbus_ctrl_inst (.ref_clk, .sys_rst, .reset_n, .shutdown_float_n, .hold_req_n,
    .ready_n, .ignore_hold_bit, .req_valid, .req_write, .req_addr, .req_wdata, .int_ack_pulse_n_exec,
    .flag_out_set, .flag_dir_set, .flag_load, .data_i, .ext_flag_pins_i, .req_ready,
    .rsp_valid, .rsp_rdata, .flag_in, .addr_o, .addr_oe, .data_o, .data_oe, .access_strobe_n,
    .ctl_oe, .read_write, .bus_hold_grant_n, .hold_grant_oe, .int_ack_pulse_n, .int_ack_pulse_n_oe,
    .ext_flag_pins_o, .ext_flag_pins_oe);
  bus_mem_model bus_mem_model_inst (.ref_clk, .access_strobe_n, .ctl_oe, .addr_o,
    .wait_cycles, .ready_n, .rd_data);
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc();
    @(posedge ref_clk) #1;
  endtask
  task automatic xfer(input logic wr, input logic [23:0] a, input logic [31:0] d,
                      input logic [3:0] w, input logic hold_mid);
    int n;
    n = 1;
    @(negedge ref_clk);
    wait_cycles = w;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    for (int i = 0; i < 20 && req_ready !== 1'b1; i++) cyc();
    chk(read_write, !wr);
    chk(addr_o, a);
    if (wr) chk(data_o, d);
    @(negedge ref_clk);
    req_valid = 1'b0;
    if (hold_mid) hold_req_n = 1'b0;
    for (int i = 0; i < 40 && access_strobe_n !== 1'b1; i++)
    begin
      cyc();
      if (access_strobe_n === 1'b0) n++;
      if (access_strobe_n === 1'b0) chk(bus_hold_grant_n, 1);
    end
    chk(access_strobe_n, 1);
    chk(n, 32'(w) + 32'd2);
    chk(rsp_valid, !wr);
    if (!wr) chk(rsp_rdata, {8'h5a, a});
  endtask
  // ==========================================
  // Scenarios
  task automatic boot_check();
    chk(ctl_oe, 0);
    reset_n = 1'b1;
    for (int i = 0; i < 10 && access_strobe_n !== 1'b0; i++) cyc();
    chk({read_write, addr_o}, 32'h0100_0000);
    for (int i = 0; i < 20 && rsp_valid !== 1'b1; i++) cyc();
    chk(rsp_rdata, 32'h5a00_0000);
  endtask
  task automatic hold_test();
    xfer(1'b1, 24'h12_3456, 32'hdead_beef, 4'h4, 1'b1);
    for (int i = 0; i < 10 && bus_hold_grant_n !== 1'b0; i++) cyc();
    chk({addr_oe, data_oe, ctl_oe, bus_hold_grant_n}, 0);
    @(negedge ref_clk);
    req_valid = 1'b1;
    repeat (6)
    begin
      cyc();
      chk({req_ready, access_strobe_n}, 1);
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    hold_req_n = 1'b1;
    for (int i = 0; i < 10 && bus_hold_grant_n !== 1'b1; i++) cyc();
    chk(bus_hold_grant_n, 1);
    xfer(1'b0, 24'h00_0abc, 32'h0000_0000, 4'h2, 1'b0);
  endtask
  task automatic ignore_test();
    @(negedge ref_clk);
    ignore_hold_bit = 1'b1;
    hold_req_n = 1'b0;
    xfer(1'b0, 24'hff_fffc, 32'h0000_0000, 4'h0, 1'b0);
    chk(bus_hold_grant_n, 1);
    @(negedge ref_clk);
    hold_req_n = 1'b1;
    @(negedge ref_clk);
    ignore_hold_bit = 1'b0;
  endtask
  task automatic int_ack_pulse_n_test();
    int n;
    n = 0;
    @(negedge ref_clk);
    int_ack_pulse_n_exec = 1'b1;
    @(negedge ref_clk);
    int_ack_pulse_n_exec = 1'b0;
    repeat (5)
    begin
      if (int_ack_pulse_n === 1'b0) n++;
      @(negedge ref_clk);
    end
    chk(n, 1);
  endtask
  task automatic flag_test();
    logic [1:0] dir [2] = '{2'h1, 2'h2};
    logic [1:0] fin [2] = '{2'h3, 2'h1};
    for (int i = 0; i < 2; i++)
    begin
      @(negedge ref_clk);
      flag_dir_set = dir[i];
      flag_out_set = 2'h1 - 2'(i);
      flag_ext = 2'h2 - 2'(i);
      flag_load = 1'b1;
      @(negedge ref_clk);
      flag_load = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk({ext_flag_pins_oe, ext_flag_pins_o, flag_in}, {dir[i], 2'h1 - 2'(i), fin[i]});
    end
  endtask
  task automatic shutdown_test();
    @(negedge ref_clk);
    shutdown_float_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk({addr_oe, data_oe, ctl_oe, hold_grant_oe, int_ack_pulse_n_oe, ext_flag_pins_oe}, 0);
    shutdown_float_n = 1'b1;
    reset_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    boot_check();
    chk(ext_flag_pins_oe, 0);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    {sys_rst, shutdown_float_n, hold_req_n} = 3'h7;
    {reset_n, ignore_hold_bit, req_valid, req_write, int_ack_pulse_n_exec, flag_load} = 6'h00;
    {flag_out_set, flag_dir_set, flag_ext, wait_cycles} = 10'h000;
    req_addr = 24'h00_0000;
    req_wdata = 32'h0000_0000;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    boot_check();
    xfer(1'b0, 24'h00_0010, 32'h0000_0000, 4'h0, 1'b0);
    xfer(1'b1, 24'h80_0001, 32'h1234_5678, 4'h3, 1'b0);
    hold_test();
    ignore_test();
    int_ack_pulse_n_test();
    flag_test();
    shutdown_test();
    results();
  end
  // Tests need some 70 cycles; a wide margin avoids false alarms
  initial
  begin
    #(25 * 4000);
    mismatches++;
    results();
  end
endmodule // testbench
`default_nettype wire
